// ### logic/cte_pkg.sv
// Purpose: Shared constants and types of the trigger and exposure block.
// Assumes: One 125 MHz clock; register offsets are byte addresses.
// Notes: Debounce counts above 4096 cycles are only defaults here.
package cte_pkg;
  // Clock period in ns.
  localparam int unsigned CLK_NS = 8;
  // Register byte offsets.
  localparam logic [15:0] OFS_TRIG_SRC = 16'h0508;
  localparam logic [15:0] OFS_TRIG_EDGE = 16'h050c;
  localparam logic [15:0] OFS_TRIG_DEB = 16'h0510;
  localparam logic [15:0] OFS_TRIG_OVL = 16'h0514;
  localparam logic [15:0] OFS_TRIG_MODE = 16'h0518;
  localparam logic [15:0] OFS_FRAMES = 16'h051c;
  localparam logic [15:0] OFS_PULSES = 16'h0520;
  localparam logic [15:0] OFS_STB_SEL = 16'h0524;
  localparam logic [15:0] OFS_EXP_DLY = 16'h0528;
  localparam logic [15:0] OFS_STB_DLY = 16'h052c;
  localparam logic [15:0] OFS_EXP_MODE = 16'h0544;
  localparam logic [15:0] OFS_EXP_DUR = 16'h0548;
  localparam logic [15:0] OFS_LINE_EN = 16'h054c;
  localparam logic [15:0] OFS_FRAME_EN = 16'h0550;
  localparam logic [15:0] OFS_LINE_VAL = 16'h0554;
  localparam logic [15:0] OFS_FRAME_VAL = 16'h0558;
  localparam logic [15:0] OFS_STB_LEN = 16'h05b8;
  localparam logic [15:0] OFS_TRIG_DIS = 16'h05bc;
  localparam logic [15:0] OFS_STATUS = 16'h05c0;
  localparam logic [15:0] OFS_SOFT_TRIG = 16'h6030;
  // Values after reset.
  localparam logic [15:0] RST_COUNT = 16'h0001;
  localparam logic [12:0] RST_LINE_VAL = 13'h1fff;
  localparam logic [23:0] RST_FRAME_VAL = 24'hffffff;
  localparam logic [23:0] RST_EXP_DUR = 24'h000001;
  // Trigger source codes.
  localparam logic [2:0] SRC_EXT = 3'h1;
  localparam logic [2:0] SRC_PULSE = 3'h2;
  localparam logic [2:0] SRC_HOST = 3'h3;
  localparam logic [2:0] SRC_SOFT = 3'h4;
  // Overlap codes.
  localparam logic [1:0] OVL_AFTER = 2'h1;
  localparam logic [1:0] OVL_NOW = 2'h2;
  // Exposure control codes.
  localparam logic [1:0] EXP_PW = 2'h1;
  localparam logic [1:0] EXP_EXT = 2'h3;
  // Debounce codes.
  localparam logic [2:0] DB_10US = 3'h4;
  localparam logic [2:0] DB_50US = 3'h5;
  localparam logic [2:0] DB_100US = 3'h1;
  localparam logic [2:0] DB_500US = 3'h6;
  localparam logic [2:0] DB_1MS = 3'h2;
  localparam logic [2:0] DB_5MS = 3'h7;
  localparam logic [2:0] DB_10MS = 3'h3;
  // Debounce times in ns and their least cycle counts.
  localparam int unsigned T10US_NS = 10000;
  localparam int unsigned T50US_NS = 50000;
  localparam int unsigned T100US_NS = 100000;
  localparam int unsigned T500US_NS = 500000;
  localparam int unsigned T1MS_NS = 1000000;
  localparam int unsigned T5MS_NS = 5000000;
  localparam int unsigned T10MS_NS = 10000000;
  localparam int unsigned CYC_10US = (T10US_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_50US = (T50US_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_100US = (T100US_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_500US = (T500US_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_1MS = (T1MS_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_5MS = (T5MS_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_10MS = (T10MS_NS + CLK_NS - 1) / CLK_NS;
  // Width of the debounce counter.
  localparam int unsigned DBW = 21;
  // Delay unit states.
  typedef enum logic [2:0] {
    DP_IDLE = 3'b001,
    DP_WAIT = 3'b010,
    DP_ON = 3'b100
  } cte_dp_state_type;
  // Sequence states.
  typedef enum logic [2:0] {
    SQ_IDLE = 3'b001,
    SQ_DELAY = 3'b010,
    SQ_EXPOSE = 3'b100
  } cte_seq_state_type;
endpackage

// ### logic/cte_filter.sv
// Purpose: Two-stage synchroniser followed by a debounce filter.
// Assumes: A zero hold count passes the synchronised level through.
// Notes: The output changes after the new level held for hold cycles.
`timescale 1ns/1ps
module cte_filter (
  input wire logic ref_clk, // Clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic pin_in, // Raw level from a pin.
  input wire logic [cte_pkg::DBW-1:0] hold, // Debounce length in cycles.
  output logic level_out // Clean level.
);
  logic meta_r;
  logic sync_r;
  logic [cte_pkg::DBW-1:0] cnt_r;

  // Two flip-flops bring the pin into the clock domain.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= pin_in;
      sync_r <= meta_r;
    end
  end

  // A level must stay different for hold cycles before it is taken.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_r <= '0;
      level_out <= 1'b0;
    end
    else if (sync_r == level_out)
      cnt_r <= '0;
    else if (cnt_r + 1'b1 >= hold)
    begin
      cnt_r <= '0;
      level_out <= sync_r;
    end
    else
      cnt_r <= cnt_r + 1'b1;
  end
endmodule

// ### logic/cte_delay_pulse.sv
// Purpose: Waits a programmed delay, then holds a pulse for a length.
// Assumes: A start while busy restarts the unit.
// Notes: The pulse rises delay+1 cycles after start; length 0 gives none.
`timescale 1ns/1ps
module cte_delay_pulse (
  input wire logic ref_clk, // Clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic start, // One-cycle start.
  input wire logic [23:0] delay, // Cycles before the pulse.
  input wire logic [23:0] length, // Cycles of the pulse.
  output logic pulse_out, // High during the pulse.
  output logic done // One cycle when the unit finishes.
);
  cte_pkg::cte_dp_state_type st_r;
  logic [23:0] cnt_r;

  // Counts down the delay, then the pulse length.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= cte_pkg::DP_IDLE;
      cnt_r <= '0;
      pulse_out <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        st_r <= cte_pkg::DP_WAIT;
        cnt_r <= delay;
        pulse_out <= 1'b0;
      end
      else
      begin
        unique case (st_r)
          cte_pkg::DP_IDLE: cnt_r <= '0;
          cte_pkg::DP_WAIT:
            if (cnt_r != '0)
              cnt_r <= cnt_r - 1'b1;
            else if (length == '0)
            begin
              done <= 1'b1;
              st_r <= cte_pkg::DP_IDLE;
            end
            else
            begin
              cnt_r <= length - 1'b1;
              pulse_out <= 1'b1;
              st_r <= cte_pkg::DP_ON;
            end
          cte_pkg::DP_ON:
            if (cnt_r != '0)
              cnt_r <= cnt_r - 1'b1;
            else
            begin
              pulse_out <= 1'b0;
              done <= 1'b1;
              st_r <= cte_pkg::DP_IDLE;
            end
          default: st_r <= cte_pkg::DP_IDLE;
        endcase
      end
    end
  end
endmodule

// ### logic/cte_trigger_regs.sv
// Purpose: Trigger and exposure registers with the sequencer they steer.
// Assumes: Exposure, delay and strobe figures count ref_clk cycles.
// Notes: Register reads return data in the cycle after the strobe.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module cte_trigger_regs #(
  parameter logic [20:0] DB_50US_CYC = 21'(cte_pkg::CYC_50US),
  parameter logic [20:0] DB_100US_CYC = 21'(cte_pkg::CYC_100US),
  parameter logic [20:0] DB_500US_CYC = 21'(cte_pkg::CYC_500US),
  parameter logic [20:0] DB_1MS_CYC = 21'(cte_pkg::CYC_1MS),
  parameter logic [20:0] DB_5MS_CYC = 21'(cte_pkg::CYC_5MS),
  parameter logic [20:0] DB_10MS_CYC = 21'(cte_pkg::CYC_10MS)
) (
  input wire logic ref_clk, // Clock, 125 MHz.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic [15:0] reg_addr, // Register byte address.
  input wire logic [31:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [31:0] reg_rdata, // Read data, cycle after reg_rd.
  input wire logic ext_trigger_pin, // External trigger pin.
  input wire logic host_trigger_pin, // Host computer trigger line.
  input wire logic internal_pulse_train, // Pulse train, same clock.
  input wire logic exposure_ctrl_pin, // External exposure control.
  output logic exposure_active, // High while exposing.
  output logic frame_start, // One cycle per frame started.
  output logic first_strobe, // First strobe output.
  output logic second_strobe, // Second strobe output.
  output logic line_period_use, // Programmed line time in use.
  output logic [12:0] line_period, // Programmed line time.
  output logic frame_period_use, // Programmed frame time in use.
  output logic [23:0] frame_period // Programmed frame time.
);
  logic [2:0] src_r;
  logic edge_r;
  logic [2:0] deb_r;
  logic [1:0] ovl_r;
  logic [2:0] tmode_r;
  logic [15:0] frames_r;
  logic [15:0] pulses_r;
  logic [1:0] stb_sel_r;
  logic [23:0] exp_dly_r;
  logic [23:0] stb_dly_r;
  logic [23:0] stb_len_r;
  logic dis_r;
  logic [1:0] exp_mode_r;
  logic [23:0] exp_dur_r;
  logic soft_evt_r;
  logic [20:0] hold;
  logic ext_lvl;
  logic host_lvl;
  logic expc_lvl;
  logic sel_lvl;
  logic prev_lvl_r;
  logic edge_evt;
  logic [15:0] pulse_cnt_r;
  logic [15:0] pulses_m1;
  logic [15:0] frames_m1;
  logic trig_evt;
  logic trig_ok;
  logic busy;
  logic start_seq;
  logic pend_r;
  cte_pkg::cte_seq_state_type st_r;
  logic [15:0] frame_cnt_r;
  logic [23:0] exp_cnt_r;
  logic exp_end;
  logic dly_done;
  logic stb_pulse;
  logic [31:0] rd_mux;

  // Trigger configuration written by software.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      src_r <= '0;
      edge_r <= 1'b0;
      deb_r <= '0;
      ovl_r <= '0;
      tmode_r <= '0;
      frames_r <= cte_pkg::RST_COUNT;
      pulses_r <= cte_pkg::RST_COUNT;
      dis_r <= 1'b0;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        cte_pkg::OFS_TRIG_SRC: src_r <= reg_wdata[2:0];
        cte_pkg::OFS_TRIG_EDGE: edge_r <= reg_wdata[0];
        cte_pkg::OFS_TRIG_DEB: deb_r <= reg_wdata[2:0];
        cte_pkg::OFS_TRIG_OVL: ovl_r <= reg_wdata[1:0];
        cte_pkg::OFS_TRIG_MODE: tmode_r <= reg_wdata[2:0];
        cte_pkg::OFS_FRAMES: frames_r <= reg_wdata[15:0];
        cte_pkg::OFS_PULSES: pulses_r <= reg_wdata[15:0];
        cte_pkg::OFS_TRIG_DIS: dis_r <= reg_wdata[0];
        default: ;
      endcase
    end
  end

  // Strobe and exposure timing written by software.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stb_sel_r <= '0;
      exp_dly_r <= '0;
      stb_dly_r <= '0;
      stb_len_r <= '0;
      exp_mode_r <= '0;
      exp_dur_r <= cte_pkg::RST_EXP_DUR;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        cte_pkg::OFS_STB_SEL: stb_sel_r <= reg_wdata[1:0];
        cte_pkg::OFS_EXP_DLY: exp_dly_r <= reg_wdata[23:0];
        cte_pkg::OFS_STB_DLY: stb_dly_r <= reg_wdata[23:0];
        cte_pkg::OFS_STB_LEN: stb_len_r <= reg_wdata[23:0];
        cte_pkg::OFS_EXP_MODE: exp_mode_r <= reg_wdata[1:0];
        cte_pkg::OFS_EXP_DUR: exp_dur_r <= reg_wdata[23:0];
        default: ;
      endcase
    end
  end

  // Line and frame time overrides go straight to the sensor timing.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      line_period_use <= 1'b0;
      line_period <= cte_pkg::RST_LINE_VAL;
      frame_period_use <= 1'b0;
      frame_period <= cte_pkg::RST_FRAME_VAL;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        cte_pkg::OFS_LINE_EN: line_period_use <= reg_wdata[0];
        cte_pkg::OFS_LINE_VAL: line_period <= reg_wdata[12:0];
        cte_pkg::OFS_FRAME_EN: frame_period_use <= reg_wdata[0];
        cte_pkg::OFS_FRAME_VAL: frame_period <= reg_wdata[23:0];
        default: ;
      endcase
    end
  end

  // A soft command only counts while software is the trigger source.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      soft_evt_r <= 1'b0;
    else
      soft_evt_r <= reg_wr && reg_addr == cte_pkg::OFS_SOFT_TRIG &&
                    src_r == cte_pkg::SRC_SOFT;
  end

  // Read multiplexer; unmapped and write-only addresses read zero.
  always_comb
  begin
    rd_mux = '0;
    unique case (reg_addr)
      cte_pkg::OFS_TRIG_SRC: rd_mux[2:0] = src_r;
      cte_pkg::OFS_TRIG_EDGE: rd_mux[0] = edge_r;
      cte_pkg::OFS_TRIG_DEB: rd_mux[2:0] = deb_r;
      cte_pkg::OFS_TRIG_OVL: rd_mux[1:0] = ovl_r;
      cte_pkg::OFS_TRIG_MODE: rd_mux[2:0] = tmode_r;
      cte_pkg::OFS_FRAMES: rd_mux[15:0] = frames_r;
      cte_pkg::OFS_PULSES: rd_mux[15:0] = pulses_r;
      cte_pkg::OFS_STB_SEL: rd_mux[1:0] = stb_sel_r;
      cte_pkg::OFS_EXP_DLY: rd_mux[23:0] = exp_dly_r;
      cte_pkg::OFS_STB_DLY: rd_mux[23:0] = stb_dly_r;
      cte_pkg::OFS_STB_LEN: rd_mux[23:0] = stb_len_r;
      cte_pkg::OFS_TRIG_DIS: rd_mux[0] = dis_r;
      cte_pkg::OFS_EXP_MODE: rd_mux[1:0] = exp_mode_r;
      cte_pkg::OFS_EXP_DUR: rd_mux[23:0] = exp_dur_r;
      cte_pkg::OFS_LINE_EN: rd_mux[0] = line_period_use;
      cte_pkg::OFS_LINE_VAL: rd_mux[12:0] = line_period;
      cte_pkg::OFS_FRAME_EN: rd_mux[0] = frame_period_use;
      cte_pkg::OFS_FRAME_VAL: rd_mux[23:0] = frame_period;
      cte_pkg::OFS_STATUS: rd_mux = {frame_cnt_r, 13'h0000, pend_r,
                                     busy, exposure_active};
      default: rd_mux = '0;
    endcase
  end

  // Read data stand for exactly one cycle after the strobe.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= '0;
    else if (reg_rd)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= '0;
  end

  // Debounce length chosen from the code.
  always_comb
  begin
    unique case (deb_r)
      cte_pkg::DB_10US: hold = 21'(cte_pkg::CYC_10US);
      cte_pkg::DB_50US: hold = DB_50US_CYC;
      cte_pkg::DB_100US: hold = DB_100US_CYC;
      cte_pkg::DB_500US: hold = DB_500US_CYC;
      cte_pkg::DB_1MS: hold = DB_1MS_CYC;
      cte_pkg::DB_5MS: hold = DB_5MS_CYC;
      cte_pkg::DB_10MS: hold = DB_10MS_CYC;
      default: hold = '0;
    endcase
  end

  // Pins are synchronised and filtered before anything reads them.
  cte_filter u_ext_filt (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin_in(ext_trigger_pin),
    .hold(hold),
    .level_out(ext_lvl)
  );

  cte_filter u_host_filt (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin_in(host_trigger_pin),
    .hold(hold),
    .level_out(host_lvl)
  );

  cte_filter u_expc_filt (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin_in(exposure_ctrl_pin),
    .hold(hold),
    .level_out(expc_lvl)
  );

  // Selected source level; no source gives a steady low.
  always_comb
  begin
    unique case (src_r)
      cte_pkg::SRC_EXT: sel_lvl = ext_lvl;
      cte_pkg::SRC_PULSE: sel_lvl = internal_pulse_train;
      cte_pkg::SRC_HOST: sel_lvl = host_lvl;
      default: sel_lvl = 1'b0;
    endcase
  end

  // Previous level for edge detection.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      prev_lvl_r <= 1'b0;
    else
      prev_lvl_r <= sel_lvl;
  end

  // Active edge per the edge bit, or a soft command.
  assign edge_evt = (edge_r ? (prev_lvl_r && !sel_lvl)
                            : (!prev_lvl_r && sel_lvl)) || soft_evt_r;

  // A count of zero is treated as one.
  assign pulses_m1 = (pulses_r == '0) ? '0 : pulses_r - 1'b1;
  assign frames_m1 = (frames_r == '0) ? '0 : frames_r - 1'b1;
  assign trig_evt = edge_evt && pulse_cnt_r >= pulses_m1;

  // Counts source pulses toward one trigger.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      pulse_cnt_r <= '0;
    else if (trig_evt)
      pulse_cnt_r <= '0;
    else if (edge_evt)
      pulse_cnt_r <= pulse_cnt_r + 1'b1;
  end

  // Acceptance of triggers with the overlap policy.
  assign trig_ok = trig_evt && !dis_r;
  assign busy = st_r != cte_pkg::SQ_IDLE;
  assign start_seq = (trig_ok && (!busy || ovl_r == cte_pkg::OVL_NOW)) ||
                     (pend_r && !busy);

  // A queued trigger; a new one in the clearing cycle merges with it and is not queued.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      pend_r <= 1'b0;
    else if (trig_ok && busy && ovl_r == cte_pkg::OVL_AFTER)
      pend_r <= 1'b1;
    else if (pend_r && !busy)
      pend_r <= 1'b0;
  end

  // Delay from trigger to exposure.
  cte_delay_pulse u_exp_dly (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .start(start_seq),
    .delay(exp_dly_r),
    .length(24'h000000),
    .pulse_out(),
    .done(dly_done)
  );

  // Strobe delay and length from the trigger.
  cte_delay_pulse u_stb (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .start(start_seq),
    .delay(stb_dly_r),
    .length(stb_len_r),
    .pulse_out(stb_pulse),
    .done()
  );

  // End of exposure: trigger level, external line, or the timer.
  always_comb
  begin
    if (exp_mode_r == cte_pkg::EXP_PW && frame_cnt_r == '0)
      exp_end = edge_r ? sel_lvl : !sel_lvl;
    else if (exp_mode_r == cte_pkg::EXP_EXT && frame_cnt_r == '0)
      exp_end = !expc_lvl;
    else
      exp_end = exp_cnt_r == 24'h000000;
  end

  // Sequencer: delay, then one exposure per frame.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= cte_pkg::SQ_IDLE;
      frame_cnt_r <= '0;
      exp_cnt_r <= '0;
      frame_start <= 1'b0;
    end
    else
    begin
      frame_start <= 1'b0;
      if (start_seq)
      begin
        st_r <= cte_pkg::SQ_DELAY;
        frame_cnt_r <= '0;
      end
      else
      begin
        unique case (st_r)
          cte_pkg::SQ_IDLE: exp_cnt_r <= '0;
          cte_pkg::SQ_DELAY:
            if (dly_done)
            begin
              st_r <= cte_pkg::SQ_EXPOSE;
              exp_cnt_r <= exp_dur_r;
              frame_start <= 1'b1;
            end
          cte_pkg::SQ_EXPOSE:
            if (!exp_end)
              exp_cnt_r <= exp_cnt_r - 1'b1;
            else if (frame_cnt_r < frames_m1)
            begin
              frame_cnt_r <= frame_cnt_r + 1'b1;
              exp_cnt_r <= exp_dur_r;
              frame_start <= 1'b1;
            end
            else
              st_r <= cte_pkg::SQ_IDLE;
          default: st_r <= cte_pkg::SQ_IDLE;
        endcase
      end
    end
  end

  // Exposure output; mode off never exposes.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      exposure_active <= 1'b0;
    else
      exposure_active <= st_r == cte_pkg::SQ_EXPOSE && !exp_end &&
                         exp_mode_r != 2'h0;
  end

  // Strobe routed to the selected outputs.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      first_strobe <= 1'b0;
      second_strobe <= 1'b0;
    end
    else
    begin
      first_strobe <= stb_pulse && stb_sel_r[0];
      second_strobe <= stb_pulse && stb_sel_r[1];
    end
  end
endmodule

// ### tb/cte_trig_model.sv
// Purpose: Far-side trigger source feeding the external, host and pulse inputs.
// Assumes: A nonzero fire value is held for exactly one cycle.
// Notes: The line idles low, as a pulled-down input would.
`timescale 1ns/1ps
module cte_trig_model (
  input wire logic ref_clk, // Clock.
  input wire logic [7:0] fire, // Pulses to send.
  output logic level // Trigger line.
);
  logic [10:0] cnt_r = 11'h000;
  // Loads eight cycles per pulse, then counts down to idle.
  always_ff @(posedge ref_clk)
  begin
    if (fire != 8'h00)
      cnt_r <= {fire, 3'h0};
    else if (cnt_r != 11'h000)
      cnt_r <= cnt_r - 11'h001;
  end
  // Each pulse is four cycles high, then four cycles low.
  assign level = cnt_r[2];
endmodule

// ### tb/cte_trigger_regs_sva.sv
// Purpose: Port-level checks of the trigger and exposure registers.
// Assumes: Strobe outputs may be gated one cycle late by the select.
// Notes: Bound into the design top below the module.
`timescale 1ns/1ps
module cte_trigger_regs_sva (
  input wire logic ref_clk, // Clock.
  input wire logic resetn, // Reset, active low.
  input wire logic [15:0] reg_addr, // Address.
  input wire logic [31:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic frame_start, // Frame pulse.
  input wire logic exposure_active, // Exposing.
  input wire logic first_strobe, // Strobe one.
  input wire logic second_strobe, // Strobe two.
  input wire logic line_period_use, // Line time in use.
  input wire logic [12:0] line_period, // Line time.
  input wire logic frame_period_use, // Frame time in use.
  input wire logic [23:0] frame_period // Frame time.
);
  logic [1:0] sel_r;
  logic hit_lv, hit_le, hit_fv, hit_fe;
  // Shadows the strobe select field.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      sel_r <= 2'h0;
    else if (reg_wr && reg_addr == cte_pkg::OFS_STB_SEL)
      sel_r <= reg_wdata[1:0];
  end
  // Write strobes aimed at the period registers.
  assign hit_lv = reg_wr && reg_addr == cte_pkg::OFS_LINE_VAL;
  assign hit_le = reg_wr && reg_addr == cte_pkg::OFS_LINE_EN;
  assign hit_fv = reg_wr && reg_addr == cte_pkg::OFS_FRAME_VAL;
  assign hit_fe = reg_wr && reg_addr == cte_pkg::OFS_FRAME_EN;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_first_off;
    !sel_r[0] && !$past(sel_r[0]) |-> !first_strobe;
  endproperty
  a_first_off: assert property (p_first_off)
    else $error("first strobe while deselected");
  property p_second_off;
    !sel_r[1] && !$past(sel_r[1]) |-> !second_strobe;
  endproperty
  a_second_off: assert property (p_second_off)
    else $error("second strobe while deselected");
  property p_line_val;
    hit_lv |=> line_period == $past(reg_wdata[12:0]);
  endproperty
  a_line_val: assert property (p_line_val)
    else $error("line time output wrong");
  property p_line_use;
    hit_le |=> line_period_use == $past(reg_wdata[0]);
  endproperty
  a_line_use: assert property (p_line_use)
    else $error("line time enable wrong");
  property p_frame_val;
    hit_fv |=> frame_period == $past(reg_wdata[23:0]);
  endproperty
  a_frame_val: assert property (p_frame_val)
    else $error("frame time output wrong");
  property p_frame_use;
    hit_fe |=> frame_period_use == $past(reg_wdata[0]);
  endproperty
  a_frame_use: assert property (p_frame_use)
    else $error("frame time enable wrong");
  property p_exp_after_fs;
    $rose(exposure_active) |-> $past(frame_start);
  endproperty
  a_exp_after_fs: assert property (p_exp_after_fs)
    else $error("exposure began without frame start");
  property p_fs_pulse;
    frame_start |=> !frame_start;
  endproperty
  a_fs_pulse: assert property (p_fs_pulse)
    else $error("frame start longer than one cycle");
endmodule
bind cte_trigger_regs cte_trigger_regs_sva i_cte_trigger_regs_sva (
  .ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .frame_start,
  .exposure_active, .first_strobe, .second_strobe, .line_period_use,
  .line_period, .frame_period_use, .frame_period
);

// ### tb/cte_trigger_regs_tb_top.sv
// Purpose: Register and trigger sequence tests of the block.
// Assumes: Latencies are counted in ref_clk cycles.
// Notes: Each trigger run tallies outputs over a 100-cycle window.
`timescale 1ns/1ps
module cte_trigger_regs_tb_top;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] fire = 8'h00;
  logic trig_level;
  logic [31:0] reg_rdata;
  logic exposure_active, frame_start, first_strobe, second_strobe;
  logic line_period_use, frame_period_use;
  logic [12:0] line_period;
  logic [23:0] frame_period;
  int fail_count = 0;
  int check_count = 0;
  int lat, nf, ne, n1, n2, lat0;
  logic [15:0] ta [10] = '{16'h0508, 16'h050c, 16'h0510, 16'h0514,
    16'h051c, 16'h0524, 16'h0528, 16'h0544, 16'h0554, 16'h05bc};
  logic [31:0] tm [10] = '{32'h7, 32'h1, 32'h7, 32'h3, 32'hffff,
    32'h3, 32'hffffff, 32'h3, 32'h1fff, 32'h1};
  // Free-running 125 MHz clock.
  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end
  cte_trigger_regs i_cte_trigger_regs (
    .ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ext_trigger_pin(trig_level), .host_trigger_pin(trig_level),
    .internal_pulse_train(trig_level), .exposure_ctrl_pin(1'b0),
    .exposure_active, .frame_start, .first_strobe, .second_strobe,
    .line_period_use, .line_period, .frame_period_use, .frame_period
  );
  cte_trig_model i_cte_trig_model (.ref_clk, .fire, .level(trig_level));
  // Counts one comparison and reports a difference.
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("FAIL %0t: got %h, want %h", $time, s, e);
    end
  endtask
  // One write cycle, then one idle cycle.
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask
  // One read cycle; data are compared in the cycle after it.
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd <= 1'b0;
    chk(reg_rdata, e);
    @(posedge ref_clk);
    #1;
  endtask
  // Fires n source pulses, or the soft command when n is 0, and tallies.
  task automatic trig(input logic [7:0] n);
    lat = 0;
    nf = 0;
    ne = 0;
    n1 = 0;
    n2 = 0;
    if (n == 8'h00)
      wr(cte_pkg::OFS_SOFT_TRIG, 32'h1);
    else
      fire <= n;
    for (int k = 1; k <= 100; k++)
    begin
      @(posedge ref_clk);
      #1;
      fire <= 8'h00;
      if (frame_start === 1'b1 && nf == 0)
        lat = k;
      nf += int'(frame_start === 1'b1);
      ne += int'(exposure_active === 1'b1);
      n1 += int'(first_strobe === 1'b1);
      n2 += int'(second_strobe === 1'b1);
    end
    $display("Trigger run ended at %0t", $time);
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Main sequence: reset values, field widths, then trigger runs.
  initial
  begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    #1;
    rd(cte_pkg::OFS_FRAMES, 32'h1);
    rd(cte_pkg::OFS_PULSES, 32'h1);
    rd(cte_pkg::OFS_TRIG_DIS, 32'h0);
    rd(cte_pkg::OFS_SOFT_TRIG, 32'h0);
    rd(16'h0600, 32'h0);
    chk({8'h00, frame_period}, 32'hffffff);
    for (int i = 0; i < 10; i++)
    begin
      wr(ta[i], 32'hffffffff);
      rd(ta[i], tm[i]);
    end
    $display("Register table test ended");
    wr(cte_pkg::OFS_LINE_EN, 32'h1);
    wr(cte_pkg::OFS_FRAME_EN, 32'h1);
    wr(cte_pkg::OFS_FRAME_VAL, 32'h123456);
    chk({30'h0, line_period_use, frame_period_use}, 32'h3);
    chk({8'h00, frame_period}, 32'h123456);
    wr(cte_pkg::OFS_TRIG_SRC, 32'h4);
    wr(cte_pkg::OFS_TRIG_EDGE, 32'h0);
    wr(cte_pkg::OFS_TRIG_DEB, 32'h0);
    wr(cte_pkg::OFS_TRIG_OVL, 32'h0);
    wr(cte_pkg::OFS_FRAMES, 32'h1);
    wr(cte_pkg::OFS_EXP_DLY, 32'h3);
    wr(cte_pkg::OFS_EXP_DUR, 32'h5);
    wr(cte_pkg::OFS_STB_DLY, 32'h1);
    wr(cte_pkg::OFS_STB_LEN, 32'h2);
    wr(cte_pkg::OFS_TRIG_DIS, 32'h0);
    for (int s = 0; s < 4; s++)
    begin
      wr(cte_pkg::OFS_STB_SEL, 32'(s));
      wr(cte_pkg::OFS_EXP_MODE, (s == 0) ? 32'h0 : 32'h2);
      trig(8'h00);
      chk(lat, 32'h5);
      chk(n1, s[0] ? 32'h2 : 32'h0);
      chk(n2, s[1] ? 32'h2 : 32'h0);
      chk(ne, (s == 0) ? 32'h0 : 32'h5);
    end
    wr(cte_pkg::OFS_FRAMES, 32'h2);
    trig(8'h00);
    chk(nf, 32'h2);
    chk(ne, 32'ha);
    wr(cte_pkg::OFS_FRAMES, 32'h1);
    wr(cte_pkg::OFS_TRIG_DIS, 32'h1);
    trig(8'h00);
    chk(nf, 32'h0);
    wr(cte_pkg::OFS_TRIG_DIS, 32'h0);
    wr(cte_pkg::OFS_TRIG_SRC, 32'h0);
    trig(8'h00);
    chk(nf, 32'h0);
    wr(cte_pkg::OFS_TRIG_SRC, 32'h1);
    trig(8'h01);
    lat0 = lat;
    wr(cte_pkg::OFS_TRIG_EDGE, 32'h1);
    wr(cte_pkg::OFS_TRIG_SRC, 32'h3);
    trig(8'h01);
    chk(lat, lat0 + 4);
    wr(cte_pkg::OFS_TRIG_EDGE, 32'h0);
    wr(cte_pkg::OFS_TRIG_SRC, 32'h2);
    trig(8'h02);
    chk(nf, 32'h1);
    wr(cte_pkg::OFS_TRIG_OVL, 32'h1);
    trig(8'h02);
    chk(nf, 32'h2);
    wr(cte_pkg::OFS_TRIG_OVL, 32'h2);
    trig(8'h02);
    chk(nf, 32'h2);
    wr(cte_pkg::OFS_TRIG_OVL, 32'h0);
    wr(cte_pkg::OFS_PULSES, 32'h2);
    trig(8'h03);
    chk(nf, 32'h1);
    summarize();
  end
endmodule
